//--- hdl/can_rx_map.vh
/*
 * Register map, field positions, reset values and mode codes of the
 * receive buffer register block.
 * Assumes a 32-bit APB with byte addresses; each register is one word.
 */
`ifndef CAN_RX_MAP_VH
`define CAN_RX_MAP_VH

// ==================================================================
// address map
`define ADDR_W 12
`define BUF_COUNT 6
`define BUF_STRIDE 12'h040
`define OFF_BUF_CTRL 12'h000
`define OFF_EXT_ID_LOW 12'h004
`define OFF_LENGTH_CODE 12'h008
`define OFF_EXT_FLAG 12'h00C
`define OFF_DATA_BYTE0 12'h010
`define ADDR_OP_MODE 12'h180
`define ADDR_DIR_SELECT 12'h184
`define ADDR_AUTO_RTR 12'h188
`define ADDR_RX_ERR_COUNT 12'h18C
`define ADDR_STATUS 12'h190

// ==================================================================
// buffer control fields
`define CTRL_FULL_BIT 7
`define CTRL_ACCEPT_ALL_BIT 6
`define CTRL_REMOTE_BIT 5
`define CTRL_RESET 8'h00

// ==================================================================
// length code fields
`define DLC_REMOTE_BIT 6
`define DLC_MAX_VALID 4'h8

// ==================================================================
// operating modes and error counter limits
`define MODE_LEGACY 2'h0
`define MODE_ENHANCED 2'h1
`define MODE_FIFO 2'h2
`define REC_RESET 8'h00
`define REC_PASSIVE_LIMIT 8'h7F
`define REC_RECOVER_VALUE 8'h77
`define REC_MAX 8'hFF
`define STATUS_PASSIVE_BIT 0

`endif

//--- hdl/can_receive_buffer_regs.v
/*
 * Receive-side register set of a CAN controller: six programmable
 * message buffers in receive mode, the receive error counter and the
 * error-passive state, all reached over an APB slave.
 * Assumes a receive engine that presents each finished frame as a
 * one-cycle strobe with its fields, and error counting events as
 * one-cycle pulses, all synchronous to pclk.
 */
// The implementer's own choices: the register addresses and the APB slave port.
//
// What this block does
// (RULE1) store received identifier bits 7..0
// (RULE2) length register bit 6 marks remote request
// (RULE3) length register bits 7,5,4 read zero
// (RULE4) length code in bits 3..0
// (RULE5) eight read-only data bytes per buffer
// (RULE6) eight-bit receive error counter, resets zero
// (RULE7) error passive when counter above 127
// (RULE8) counter never causes bus-off
// (RULE9) six buffers, transmit or receive each
// (RULE10) buffers may answer remote requests automatically
// (RULE11) buffers unused in mode 0
// (RULE12) select bit 0 means receive mode
// (RULE13) set full flag on storing message
// (RULE14) no load while full; software clears
// (RULE15) accept-all bit bypasses filters and validity
// (RULE16) control bit 5 shows stored remote request
// (RULE17) control bits 4..0 hold filter hit
// (RULE18) software checks full, reads, then clears
// (RULE19) extended flag set for extended frames
// (RULE20) message registers frozen while full
`timescale 1ns/10ps
`include "can_rx_map.vh"

module can_receive_buffer_regs
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire msg_strobe,
	input wire msg_ok,
	input wire msg_filter_match,
	input wire [4:0] filter_hit_index,
	input wire extended_frame_flag,
	input wire rx_remote_req_flag,
	input wire [7:0] ext_id_low_bits,
	input wire [3:0] length_code_bits,
	input wire [63:0] msg_data,
	input wire rec_inc_one,
	input wire rec_inc_eight,
	input wire rec_dec_one,
	input wire rec_clear,
	output reg error_passive,
	output reg [5:0] buffer_full,
	output reg [5:0] auto_rtr_request
);

	// ==================================================================
	// decoding helpers

	// buffer index of an address, 7 when outside the buffer window
	function [2:0] buf_index;
		input [11:0] addr;
		begin
			if (addr < (`BUF_STRIDE * `BUF_COUNT))
				buf_index = addr[8:6];
			else
				buf_index = 3'h7;
		end
	endfunction

	// true when a length code asks for this data byte
	function byte_used;
		input [3:0] code;
		input [2:0] idx;
		begin
			byte_used = ({1'b0, idx} < code);
		end
	endfunction

	// ==================================================================
	// storage

	reg [7:0] ctrl_reg [0:5];
	reg [7:0] ext_id_low_reg [0:5];
	reg [7:0] length_code_reg [0:5];
	reg [5:0] ext_flag_reg;
	reg [7:0] data_reg [0:47];
	reg [1:0] op_mode_reg;
	reg [5:0] buffer_direction_select_reg;
	reg [5:0] auto_rtr_enable_reg;
	reg [7:0] rx_error_count_reg;
	reg [7:0] rx_error_count_next;
	reg [31:0] rd_next;
	reg rd_err;
	reg [5:0] grant;
	reg [5:0] taken;
	integer i;
	integer j;
	integer k;
	integer n;

	wire [11:0] addr = paddr[11:0];
	wire [2:0] sel_buf = buf_index(addr);
	wire [5:0] in_buf = addr[5:0];
	wire setup_phase = psel & ~penable;
	// an erroring access must not touch any register
	wire wr_commit = psel & penable & pready & pwrite & ~pslverr;
	wire bufs_enabled = (op_mode_reg == `MODE_ENHANCED) ||
		(op_mode_reg == `MODE_FIFO); // RULE11
	wire [5:0] eligible;

	// ==================================================================
	// per-buffer acceptance

	// a buffer takes a frame only in receive mode and while open
	genvar g;
	generate
		for (g = 0; g < `BUF_COUNT; g = g + 1)
		begin : accept_gen
			assign eligible[g] = msg_strobe & bufs_enabled &
				~buffer_direction_select_reg[g] & // RULE12
				~ctrl_reg[g][`CTRL_FULL_BIT] & // RULE14
				(ctrl_reg[g][`CTRL_ACCEPT_ALL_BIT] |
				(msg_ok & msg_filter_match)); // RULE15
		end
	endgenerate

	// lowest-numbered eligible buffer wins so a frame lands only once
	always @*
	begin
		grant = 6'h00;
		taken = 6'h00;
		for (k = 0; k < `BUF_COUNT; k = k + 1)
		begin
			grant[k] = eligible[k] & ~(|taken);
			taken[k] = eligible[k];
		end
	end

	// ==================================================================
	// buffer registers

	// load on grant, software clears full by writing 0 to bit 7;
	// a load in the same cycle as the clear still leaves full set
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (i = 0; i < `BUF_COUNT; i = i + 1)
			begin
				ctrl_reg[i] <= `CTRL_RESET;
				ext_id_low_reg[i] <= 8'h00;
				length_code_reg[i] <= 8'h00;
			end
			ext_flag_reg <= 6'h00;
			for (j = 0; j < 48; j = j + 1)
				data_reg[j] <= 8'h00;
		end
		else
		begin
			for (i = 0; i < `BUF_COUNT; i = i + 1)
			begin
				if (wr_commit && bufs_enabled && sel_buf == i &&
					in_buf == `OFF_BUF_CTRL)
				begin
					ctrl_reg[i][`CTRL_ACCEPT_ALL_BIT] <=
						pwdata[`CTRL_ACCEPT_ALL_BIT];
					if (!pwdata[`CTRL_FULL_BIT])
						ctrl_reg[i][`CTRL_FULL_BIT] <= 1'b0; // RULE14
				end
				if (grant[i]) // RULE20
				begin
					ctrl_reg[i][`CTRL_FULL_BIT] <= 1'b1; // RULE13
					ctrl_reg[i][`CTRL_REMOTE_BIT] <=
						rx_remote_req_flag; // RULE16
					ctrl_reg[i][4:0] <= filter_hit_index; // RULE17
					ext_id_low_reg[i] <= ext_id_low_bits; // RULE1
					ext_flag_reg[i] <= extended_frame_flag; // RULE19
					length_code_reg[i] <= {1'b0, rx_remote_req_flag,
						2'b00, length_code_bits}; // RULE2 RULE3 RULE4
					for (j = 0; j < 8; j = j + 1)
						data_reg[i * 8 + j] <=
							byte_used(length_code_bits, j[2:0]) ?
							msg_data[j * 8 +: 8] : 8'h00; // RULE5
				end
			end
		end
	end

	// ==================================================================
	// global control registers

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_mode_reg <= `MODE_LEGACY;
			buffer_direction_select_reg <= 6'h00;
			auto_rtr_enable_reg <= 6'h00;
		end
		else if (wr_commit)
		begin
			case (addr)
				`ADDR_OP_MODE:
					op_mode_reg <= pwdata[1:0];
				`ADDR_DIR_SELECT:
					buffer_direction_select_reg <= pwdata[5:0]; // RULE9
				`ADDR_AUTO_RTR:
					auto_rtr_enable_reg <= pwdata[5:0]; // RULE10
				default:
					op_mode_reg <= op_mode_reg;
			endcase
		end
	end

	// ==================================================================
	// receive error counter

	// saturating counter; a good frame while passive drops back
	// into the active range, as the bus standard allows
	always @*
	begin
		rx_error_count_next = rx_error_count_reg;
		if (rec_clear)
			rx_error_count_next = `REC_RESET;
		else if (rec_inc_eight)
			rx_error_count_next = (rx_error_count_reg > 8'hF7) ?
				`REC_MAX : rx_error_count_reg + 8'h08;
		else if (rec_inc_one)
			rx_error_count_next = (rx_error_count_reg == `REC_MAX) ?
				`REC_MAX : rx_error_count_reg + 8'h01;
		else if (rec_dec_one)
		begin
			if (rx_error_count_reg > `REC_PASSIVE_LIMIT)
				rx_error_count_next = `REC_RECOVER_VALUE;
			else if (rx_error_count_reg != 8'h00)
				rx_error_count_next = rx_error_count_reg - 8'h01;
		end
	end

	// no bus-off output exists here: the receive count cannot
	// reach bus-off, only the transmit side can
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_error_count_reg <= `REC_RESET; // RULE6
			error_passive <= 1'b0;
		end
		else
		begin
			rx_error_count_reg <= rx_error_count_next; // RULE6 RULE8
			error_passive <=
				(rx_error_count_next > `REC_PASSIVE_LIMIT); // RULE7
		end
	end

	// ==================================================================
	// side-band outputs

	// remote request that hit filter n arms transmit buffer n
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buffer_full <= 6'h00;
			auto_rtr_request <= 6'h00;
		end
		else
		begin
			for (n = 0; n < `BUF_COUNT; n = n + 1)
			begin
				buffer_full[n] <= ctrl_reg[n][`CTRL_FULL_BIT] |
					grant[n];
				auto_rtr_request[n] <= msg_strobe & msg_ok &
					msg_filter_match & rx_remote_req_flag &
					bufs_enabled & buffer_direction_select_reg[n] &
					auto_rtr_enable_reg[n] &
					(filter_hit_index == n); // RULE10
			end
		end
	end

	// ==================================================================
	// read multiplexer

	// buffer registers read zero in mode 0 since they are not in use
	always @*
	begin
		rd_next = 32'h0000_0000;
		rd_err = 1'b0;
		if (sel_buf != 3'h7)
		begin
			if (!bufs_enabled)
				rd_next = 32'h0000_0000; // RULE11
			else if (in_buf == `OFF_BUF_CTRL)
				rd_next = {24'h00_0000, ctrl_reg[sel_buf]};
			else if (in_buf == `OFF_EXT_ID_LOW)
				rd_next = {24'h00_0000, ext_id_low_reg[sel_buf]};
			else if (in_buf == `OFF_LENGTH_CODE)
				rd_next = {24'h00_0000, length_code_reg[sel_buf]};
			else if (in_buf == `OFF_EXT_FLAG)
				rd_next = {31'h0000_0000, ext_flag_reg[sel_buf]};
			else if (in_buf >= `OFF_DATA_BYTE0 && in_buf[1:0] == 2'b00 &&
				in_buf < 6'h30)
				// byte m sits at +0x10 + 4m, so m is word offset minus 4
				rd_next = {24'h00_0000,
					data_reg[{sel_buf, ~in_buf[4], in_buf[3:2]}]}; // RULE5
			else
				rd_err = 1'b1;
		end
		else
		begin
			case (addr)
				`ADDR_OP_MODE:
					rd_next = {30'h0000_0000, op_mode_reg};
				`ADDR_DIR_SELECT:
					rd_next = {26'h000_0000, buffer_direction_select_reg};
				`ADDR_AUTO_RTR:
					rd_next = {26'h000_0000, auto_rtr_enable_reg};
				`ADDR_RX_ERR_COUNT:
					rd_next = {24'h00_0000, rx_error_count_reg};
				`ADDR_STATUS:
					rd_next = {31'h0000_0000, error_passive};
				default:
					rd_err = 1'b1;
			endcase
		end
		if (paddr[31:12] != 20'h0_0000)
		begin
			rd_next = 32'h0000_0000;
			rd_err = 1'b1;
		end
	end

	// ==================================================================
	// apb response

	// answer is prepared in the setup cycle, so every access
	// completes with no wait state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup_phase;
			pslverr <= setup_phase & rd_err;
			if (setup_phase && !pwrite)
				prdata <= rd_next;
		end
	end

endmodule // can_receive_buffer_regs

//--- bench/can_rx_regs_props.sv
/* checker for the receive buffer register block
   sees only top ports; pclk is the single clock domain */
`timescale 1ns/10ps
module can_rx_regs_props
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire msg_strobe,
	input wire rx_remote_req_flag,
	input wire [4:0] filter_hit_index,
	input wire rec_inc_one,
	input wire rec_inc_eight,
	input wire rec_dec_one,
	input wire rec_clear,
	input wire error_passive,
	input wire [5:0] buffer_full,
	input wire [5:0] auto_rtr_request
);
// ==========
// bus, buffer and counter properties
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// setup cycle of a transfer
sequence s_setup;
	psel && !penable;
endsequence
a_ready_access:
	assert property (s_setup |=> pready) else $error("no ready");
a_ready_single:
	assert property (pready |=> !pready) else $error("ready too long");
a_err_high:
	assert property (s_setup ##0 paddr[31:12] != 20'h0_0000 |=> pslverr)
	else $error("high address not refused");
a_passive_clear:
	assert property (rec_clear |=> !error_passive) else $error("passive");
a_passive_rise:
	assert property ($rose(error_passive) |-> $past(rec_inc_one
		|| rec_inc_eight)) else $error("passive without increment");
a_passive_keep:
	assert property (error_passive && !rec_clear && !rec_dec_one
		|=> error_passive) else $error("passive lost");
a_full_cause:
	assert property ((buffer_full & ~$past(buffer_full)) != 6'h00
		|-> $past(msg_strobe)) else $error("full without frame");
a_one_load:
	assert property ($countones(buffer_full & ~$past(buffer_full)) <= 1)
	else $error("frame loaded twice");
a_full_drop:
	assert property ((~buffer_full & $past(buffer_full)) != 6'h00
		|-> $past(psel && penable && pwrite, 2)) else $error("full lost");
a_rtr_pulse:
	assert property (auto_rtr_request != 6'h00
		|-> $past(msg_strobe && rx_remote_req_flag)
		&& auto_rtr_request == (6'h01 << $past(filter_hit_index)))
	else $error("bad auto remote pulse");
endmodule // can_rx_regs_props
bind can_receive_buffer_regs can_rx_regs_props i_can_rx_regs_props (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
	.msg_strobe, .rx_remote_req_flag, .filter_hit_index, .rec_inc_one,
	.rec_inc_eight, .rec_dec_one, .rec_clear, .error_passive, .buffer_full,
	.auto_rtr_request);

//--- bench/can_frame_source.sv
/* frame source standing for the other nodes on the bus
   drives the message port and error pulses after pclk edges */
`timescale 1ns/10ps
module can_frame_source
(
	input wire pclk,
	output logic msg_strobe,
	output logic msg_ok,
	output logic msg_filter_match,
	output logic [4:0] filter_hit_index,
	output logic extended_frame_flag,
	output logic rx_remote_req_flag,
	output logic [7:0] ext_id_low_bits,
	output logic [3:0] length_code_bits,
	output logic [63:0] msg_data,
	output logic rec_inc_one,
	output logic rec_inc_eight,
	output logic rec_dec_one,
	output logic rec_clear
);
// ==========
// idle state
initial
begin
	msg_strobe = 1'b0;
	{msg_ok, msg_filter_match, extended_frame_flag, rx_remote_req_flag} = 4'h0;
	{ext_id_low_bits, length_code_bits, msg_data, filter_hit_index} = 81'h0;
	{rec_clear, rec_inc_eight, rec_inc_one, rec_dec_one} = 4'h0;
end
// one frame after gap edges; fields inverted after so stale values fail
task send(input [7:0] id, input [3:0] dlc, input [63:0] d, input [4:0] hit,
	input [3:0] fl, input int gap);
begin
	repeat (gap) @(posedge pclk);
	{msg_ok, msg_filter_match, extended_frame_flag, rx_remote_req_flag} <= fl;
	{ext_id_low_bits, length_code_bits, msg_data, filter_hit_index} <=
		{id, dlc, d, hit};
	msg_strobe <= 1'b1;
	@(posedge pclk);
	msg_strobe <= 1'b0;
	{ext_id_low_bits, length_code_bits, msg_data, filter_hit_index} <=
		~{id, dlc, d, hit};
end
endtask
// one error pulse {clear, inc8, inc1, dec}, then an idle edge
task err(input [3:0] c);
begin
	{rec_clear, rec_inc_eight, rec_inc_one, rec_dec_one} <= c;
	@(posedge pclk);
	{rec_clear, rec_inc_eight, rec_inc_one, rec_dec_one} <= 4'h0;
	@(posedge pclk);
end
endtask
endmodule // can_frame_source

//--- bench/test_can_receive_buffer_regs.sv
/* self-checking bench of the receive buffer register block
   assumes the frame source model and the bound checker */
`timescale 1ns/10ps
`include "can_rx_map.vh"
`define CHK(g, e) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("[FAIL] %0t got %h exp %h", $time, g, e); \
		end \
	end
module test_can_receive_buffer_regs;
// ==========
// wiring
logic pclk = 1'b0;
logic presetn = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [31:0] paddr = 32'h0000_0000;
logic [31:0] pwdata = 32'h0000_0000;
logic [31:0] rdat;
logic last_err;
wire [31:0] prdata;
wire pready, pslverr, error_passive, msg_strobe, msg_ok, msg_filter_match;
wire extended_frame_flag, rx_remote_req_flag, rec_inc_one, rec_inc_eight;
wire rec_dec_one, rec_clear;
wire [4:0] filter_hit_index;
wire [7:0] ext_id_low_bits;
wire [3:0] length_code_bits;
wire [63:0] msg_data;
wire [5:0] buffer_full, auto_rtr_request;
int n_fail = 0;
int num_checks = 0;
int i;
can_receive_buffer_regs i_can_receive_buffer_regs (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.msg_strobe, .msg_ok, .msg_filter_match, .filter_hit_index,
	.extended_frame_flag, .rx_remote_req_flag, .ext_id_low_bits,
	.length_code_bits, .msg_data, .rec_inc_one, .rec_inc_eight, .rec_dec_one,
	.rec_clear, .error_passive, .buffer_full, .auto_rtr_request);
can_frame_source f (.pclk, .msg_strobe, .msg_ok, .msg_filter_match,
	.filter_hit_index, .extended_frame_flag, .rx_remote_req_flag,
	.ext_id_low_bits, .length_code_bits, .msg_data, .rec_inc_one,
	.rec_inc_eight, .rec_dec_one, .rec_clear);
// 50 MHz clock
always #10 pclk = ~pclk;
// ==========
// tasks
task finish_test;
begin
	if (n_fail == 0 && num_checks > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
end
endtask
// one transfer; a free edge after it keeps psel from toggling twice
task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
	int k;
begin
	{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
	@(posedge pclk);
	penable <= 1'b1;
	k = 0;
	do
	begin
		@(posedge pclk);
		k++;
	end
	while (pready !== 1'b1 && k < 16);
	if (pready !== 1'b1)
	begin
		n_fail++;
		finish_test;
	end
	{rdat, last_err} = {prdata, pslverr};
	{psel, penable} <= 2'b00;
	@(posedge pclk);
end
endtask
task rd(input logic [11:0] a, input logic [31:0] e);
begin
	apb(1'b0, {20'h0_0000, a}, 32'h0000_0000);
	`CHK(rdat, e)
end
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
	apb(1'b1, {20'h0_0000, a}, d);
endtask
function logic [11:0] ba(input int n, input logic [11:0] off);
	return off + n[11:0] * `BUF_STRIDE;
endfunction
// ==========
// main sequence
initial
begin
	repeat (4) @(posedge pclk);
	presetn <= 1'b1;
	rd(`ADDR_RX_ERR_COUNT, 32'h0000_0000);
	apb(1'b0, 32'h0000_1000, 32'h0000_0000);
	`CHK(last_err, 1'b1)
	f.send(8'h11, 4'h1, 64'h0, 5'h00, 4'b1100, 1);
	wr(`ADDR_OP_MODE, 32'h0000_0001);
	rd(ba(0, `OFF_BUF_CTRL), 32'h0000_0000);
	wr(`ADDR_DIR_SELECT, 32'h0000_0001);
	wr(ba(4, `OFF_BUF_CTRL), 32'h0000_00FF);
	rd(ba(4, `OFF_BUF_CTRL), 32'h0000_0040);
	wr(ba(4, `OFF_BUF_CTRL), 32'h0000_0000);
	wr(ba(2, `OFF_BUF_CTRL), 32'h0000_0040);
	f.send(8'hA5, 4'h8, 64'h8877_6655_4433_2211, 5'h0F, 4'b1110, 1);
	f.send(8'h3C, 4'hF, 64'h0, 5'h00, 4'b0001, 1);
	f.send(8'h5A, 4'h2, 64'hFFFF_FFFF_FFFF_BEEF, 5'h07, 4'b1100, 3);
	f.send(8'h66, 4'h1, 64'h0, 5'h01, 4'b0100, 1);
	@(posedge pclk);
	`CHK(buffer_full, 6'h0E)
	rd(ba(1, `OFF_BUF_CTRL), 32'h0000_008F);
	rd(ba(1, `OFF_EXT_ID_LOW), 32'h0000_00A5);
	rd(ba(1, `OFF_LENGTH_CODE), 32'h0000_0008);
	rd(ba(1, `OFF_EXT_FLAG), 32'h0000_0001);
	for (i = 0; i < 8; i++)
		rd(ba(1, `OFF_DATA_BYTE0) + 12'(4 * i), 32'(8'h11 * (i + 1)));
	rd(ba(2, `OFF_BUF_CTRL), 32'h0000_00E0);
	rd(ba(2, `OFF_LENGTH_CODE), 32'h0000_004F);
	rd(ba(3, `OFF_LENGTH_CODE), 32'h0000_0002);
	rd(ba(3, `OFF_EXT_FLAG), 32'h0000_0000);
	rd(ba(3, `OFF_DATA_BYTE0) + 12'h004, 32'h0000_00BE);
	wr(ba(1, `OFF_BUF_CTRL), 32'h0000_0000);
	f.send(8'h77, 4'h0, 64'h0, 5'h02, 4'b1100, 1);
	rd(ba(1, `OFF_EXT_ID_LOW), 32'h0000_0077);
	rd(ba(1, `OFF_BUF_CTRL), 32'h0000_0082);
	// counter walks to 127, then one more crosses into passive
	for (i = 0; i < 15; i++)
		f.err(4'b0100);
	for (i = 0; i < 7; i++)
		f.err(4'b0010);
	`CHK(error_passive, 1'b0)
	f.err(4'b0010);
	rd(`ADDR_RX_ERR_COUNT, 32'h0000_0080);
	rd(`ADDR_STATUS, 32'h0000_0001);
	f.err(4'b0001);
	rd(`ADDR_RX_ERR_COUNT, 32'h0000_0077);
	f.err(4'b1000);
	rd(`ADDR_RX_ERR_COUNT, 32'h0000_0000);
	wr(`ADDR_AUTO_RTR, 32'h0000_0001);
	f.send(8'h01, 4'h0, 64'h0, 5'h00, 4'b1101, 1);
	// the request pulse stands for the one cycle after the strobe edge
	@(posedge pclk);
	`CHK(auto_rtr_request, 6'h01)
	finish_test;
end
endmodule // test_can_receive_buffer_regs
